// ### hdl/psl_link.sv
// 28-bit parallel to four-lane serial link: transmitter and receiver halves
// What this block does
// - Transmitter captures the whole parallel word on each rising edge of its strobe clock.
// - Each captured word is spread over four lanes, each a true/complement pair.
// - A fifth pair forwards the frame clock beside the data lanes.
// - Transmitter power-down low drives all serial outputs low and drops link_out_en.
// - Receiver rebuilds the full parallel word from the four lanes.
// - Receiver strobe clock output rises while the parallel word is valid.
// - Receiver power-down low forces all parallel outputs low, not held.
// - A floating or merely terminated receiver data input reads as high.
// - Forwarded clock present with floating data gives an all-ones word.
// - Floating forwarded clock keeps the last valid received word.
// - Floating forwarded clock holds the receiver strobe clock output high.
// - Each lane carries seven bits per parallel clock period.
// - Latency is one period through transmit plus two periods through receive.
// - Serial outputs toggle only after the multiplier lock wait of 10 ms.
module psl_link
	import psl_pkg::*;
#(
	parameter int unsigned LOCK_CYCLES_P = LOCK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic link_clk,
	input wire logic parallel_strobe_clock_in,
	input wire logic [27:0] parallel_word_in,
	input wire logic tx_power_down_n,
	output logic [3:0] serial_lane_out_true,
	output logic [3:0] serial_lane_out_comp,
	output logic forwarded_clock_out_true,
	output logic forwarded_clock_out_comp,
	output logic link_out_en,
	input wire logic [3:0] serial_lane_in_true,
	input wire logic [3:0] serial_lane_in_comp,
	input wire logic forwarded_clock_in_true,
	input wire logic forwarded_clock_in_comp,
	input wire logic rx_power_down_n,
	output logic [27:0] parallel_word_out,
	output logic parallel_strobe_clock_out
);

	// Transmit state, ref_clk domain; ref_clk is the serial bit clock
	typedef struct packed {
		psl_tx_state_e state;
		logic [LOCK_CNT_W-1:0] lock_cnt;
		logic strobe_prev;
		logic [2:0] slot;
		logic [27:0] shift;
		logic [3:0] lane_t;
		logic [3:0] lane_c;
		logic fclk_t;
		logic fclk_c;
		logic oe;
	} psl_tx_s;

	// Receive state on the link clock
	typedef struct packed {
		logic fclk_prev;
		logic [2:0] slot;
		logic [27:0] assembly;
		logic float_seen;
		logic [27:0] stage;
		logic stage_valid;
		logic [27:0] xfer;
		logic xfer_tgl;
	} psl_rxl_s;

	// Receive output state, ref_clk domain
	typedef struct packed {
		logic tgl_seen;
		logic [27:0] word;
		logic strobe;
		logic [2:0] strobe_cnt;
		logic [7:0] idle_cnt;
	} psl_rxo_s;

	psl_tx_s tx_q;
	psl_tx_s tx_d;
	psl_rxl_s rxl_q;
	psl_rxl_s rxl_d;
	psl_rxo_s rxo_q;
	psl_rxo_s rxo_d;

	logic [31:0] ref_sync_q;
	logic [11:0] link_sync_q;

	logic [27:0] word_sync;
	logic strobe_sync;
	logic tx_pd_n_sync;
	logic rx_pd_n_sync;
	logic tgl_sync;

	logic [3:0] lane_t_sync;
	logic [3:0] lane_c_sync;
	logic fclk_t_sync;
	logic fclk_c_sync;
	logic link_rst;
	logic link_ce;

	logic strobe_rise;
	logic [3:0] lane_bit;
	logic [3:0] lane_float;
	logic clk_ok;
	logic clk_bit;
	logic [2:0] slot_now;
	logic [27:0] assembly_v;
	logic new_word;

	// Pins and the link toggle into ref_clk
	psl_sync #(
		.W(32)
	) u_ref_sync (
		.clk(ref_clk),
		.rst(rst),
		.en(ce),
		.d({rxl_q.xfer_tgl, rx_power_down_n, tx_power_down_n,
			parallel_strobe_clock_in, parallel_word_in}),
		.q(ref_sync_q)
	);

	assign word_sync = ref_sync_q[27:0];
	assign strobe_sync = ref_sync_q[28];
	assign tx_pd_n_sync = ref_sync_q[29];
	assign rx_pd_n_sync = ref_sync_q[30];
	assign tgl_sync = ref_sync_q[31];

	// Lane pins, reset and enable into the link domain; no reset of its own
	psl_sync #(
		.W(12)
	) u_link_sync (
		.clk(link_clk),
		.rst(1'b0),
		.en(1'b1),
		.d({ce, rst, forwarded_clock_in_comp, forwarded_clock_in_true,
			serial_lane_in_comp, serial_lane_in_true}),
		.q(link_sync_q)
	);

	assign lane_t_sync = link_sync_q[3:0];
	assign lane_c_sync = link_sync_q[7:4];
	assign fclk_t_sync = link_sync_q[8];
	assign fclk_c_sync = link_sync_q[9];
	assign link_rst = link_sync_q[10];
	assign link_ce = link_sync_q[11];

	// Transmitter: capture, lock wait and serialiser
	always_comb begin
		tx_d = tx_q;
		strobe_rise = strobe_sync & ~tx_q.strobe_prev;
		tx_d.strobe_prev = strobe_sync;
		// Frame restarts on the host edge so a frame never mixes two words
		if (strobe_rise) begin
			tx_d.shift = word_sync;
			tx_d.slot = SLOT_FIRST;
		end else if (tx_q.slot == SLOT_LAST) begin
			tx_d.slot = SLOT_FIRST;
		end else begin
			tx_d.slot = 3'(tx_q.slot + 3'h1);
		end
		// Power state: outputs stay released until the lock wait is over
		if (!tx_pd_n_sync) begin
			tx_d.state = TX_OFF;
			tx_d.lock_cnt = '0;
		end else begin
			unique case (tx_q.state)
				TX_OFF: begin
					tx_d.state = TX_LOCKING;
					tx_d.lock_cnt = LOCK_CNT_W'(LOCK_CYCLES_P - 1);
				end
				TX_LOCKING: begin
					if (tx_q.lock_cnt == '0) begin
						tx_d.state = TX_RUN;
					end else begin
						tx_d.lock_cnt = tx_q.lock_cnt - 1'b1;
					end
				end
				TX_RUN: begin
					tx_d.state = TX_RUN;
				end
				default: begin
					tx_d.state = TX_OFF;
				end
			endcase
		end
		tx_d.oe = (tx_d.state == TX_RUN);
		// Lane bits for the slot about to go out
		for (int l = 0; l < LANES; l++) begin
			tx_d.lane_t[l] = tx_d.oe & tx_d.shift[bit_pos(l, int'(tx_d.slot))];
			tx_d.lane_c[l] = tx_d.oe & ~tx_d.shift[bit_pos(l, int'(tx_d.slot))];
		end
		tx_d.fclk_t = tx_d.oe & FWD_CLK_PATTERN[tx_d.slot];
		tx_d.fclk_c = tx_d.oe & ~FWD_CLK_PATTERN[tx_d.slot];
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_q <= '0;
		end else if (ce) begin
			tx_q <= tx_d;
		end
	end

	// Serial pins come straight from flip-flops
	assign serial_lane_out_true = tx_q.lane_t;
	assign serial_lane_out_comp = tx_q.lane_c;
	assign forwarded_clock_out_true = tx_q.fclk_t;
	assign forwarded_clock_out_comp = tx_q.fclk_c;
	assign link_out_en = tx_q.oe;

	// Pair decode; equal levels mean the failsafe bias pulls the pair high
	always_comb begin
		for (int l = 0; l < LANES; l++) begin
			lane_bit[l] = lane_t_sync[l] | ~lane_c_sync[l];
			lane_float[l] = ~(lane_t_sync[l] ^ lane_c_sync[l]);
		end
		clk_ok = fclk_t_sync ^ fclk_c_sync;
		clk_bit = fclk_t_sync | ~fclk_c_sync;
	end

	// Receiver deserialiser on the link clock
	always_comb begin
		rxl_d = rxl_q;
		slot_now = SLOT_IDLE;
		assembly_v = rxl_q.assembly;
		rxl_d.fclk_prev = clk_bit & clk_ok;
		if (clk_ok) begin
			// Rising forwarded clock marks slot zero of a frame
			if (clk_bit && !rxl_q.fclk_prev) begin
				slot_now = SLOT_FIRST;
			end else if (rxl_q.slot == SLOT_IDLE || rxl_q.slot == SLOT_LAST) begin
				slot_now = SLOT_IDLE;
			end else begin
				slot_now = 3'(rxl_q.slot + 3'h1);
			end
		end
		// A lost clock leaves the slot idle, so nothing completes
		rxl_d.slot = slot_now;
		if (slot_now != SLOT_IDLE) begin
			for (int l = 0; l < LANES; l++) begin
				assembly_v[bit_pos(l, int'(slot_now))] = lane_bit[l];
			end
			if (slot_now == SLOT_FIRST) begin
				rxl_d.float_seen = |lane_float;
			end else begin
				rxl_d.float_seen = rxl_q.float_seen | (|lane_float);
			end
		end
		rxl_d.assembly = assembly_v;
		// Frame complete: the older frame crosses, the new one waits a period
		if (slot_now == SLOT_LAST) begin
			if (rxl_q.stage_valid) begin
				rxl_d.xfer = rxl_q.stage;
				rxl_d.xfer_tgl = ~rxl_q.xfer_tgl;
			end
			if (rxl_d.float_seen) begin
				rxl_d.stage = WORD_ALL_ONES;
			end else begin
				rxl_d.stage = assembly_v;
			end
			rxl_d.stage_valid = 1'b1;
		end
	end

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			rxl_q <= '0;
			rxl_q.slot <= SLOT_IDLE;
		end else if (link_ce) begin
			rxl_q <= rxl_d;
		end
	end

	// Receive outputs in ref_clk; xfer is stable for a whole frame after its toggle
	always_comb begin
		rxo_d = rxo_q;
		new_word = tgl_sync ^ rxo_q.tgl_seen;
		rxo_d.tgl_seen = tgl_sync;
		if (!rx_pd_n_sync) begin
			rxo_d.word = WORD_RESET;
			rxo_d.strobe = 1'b0;
			rxo_d.strobe_cnt = '0;
			rxo_d.idle_cnt = '0;
		end else if (new_word) begin
			// Strobe drops with the update and rises once the word has settled
			rxo_d.word = rxl_q.xfer;
			rxo_d.strobe = 1'b0;
			rxo_d.strobe_cnt = STROBE_LOW_CYCLES;
			rxo_d.idle_cnt = '0;
		end else begin
			if (rxo_q.strobe_cnt != '0) begin
				rxo_d.strobe_cnt = 3'(rxo_q.strobe_cnt - 3'h1);
				if (rxo_q.strobe_cnt == 3'h1) begin
					rxo_d.strobe = 1'b1;
				end
			end
			// No frames for a while means the forwarded clock is gone
			if (rxo_q.idle_cnt != RX_IDLE_CYCLES) begin
				rxo_d.idle_cnt = 8'(rxo_q.idle_cnt + 8'h01);
			end else begin
				rxo_d.strobe = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rxo_q <= '0;
		end else if (ce) begin
			rxo_q <= rxo_d;
		end
	end

	// Word held between frames keeps the last valid value
	assign parallel_word_out = rxo_q.word;
	assign parallel_strobe_clock_out = rxo_q.strobe;

endmodule

// ### hdl/psl_pkg.sv
// Shared constants, encodings and the bit-to-slot map of the serial link
package psl_pkg;

	// Word and frame geometry
	localparam int WORD_W = 28;
	localparam int LANES = 4;
	localparam int SLOTS = 7;

	// Slot counter codes; the idle code marks "no frame in progress"
	localparam logic [2:0] SLOT_FIRST = 3'h0;
	localparam logic [2:0] SLOT_LAST = 3'h6;
	localparam logic [2:0] SLOT_IDLE = 3'h7;

	// Forwarded clock shape over one frame, bit s drives slot s
	localparam logic [6:0] FWD_CLK_PATTERN = 7'h0f;

	// Multiplier lock wait after power-down release
	localparam int REF_CLK_HZ = 50_000_000;
	localparam int LOCK_TIME_MS = 10;
	localparam int LOCK_CYCLES = LOCK_TIME_MS * (REF_CLK_HZ / 1000);
	localparam int LOCK_CNT_W = 19;

	// Receive side strobe shaping and lost-clock watchdog, in ref_clk cycles
	localparam logic [2:0] STROBE_LOW_CYCLES = 3'h2;
	localparam logic [7:0] RX_IDLE_CYCLES = 8'h40;

	// Reset and failsafe word values
	localparam logic [27:0] WORD_RESET = 28'h000_0000;
	localparam logic [27:0] WORD_ALL_ONES = 28'hfff_ffff;

	// Transmit power state, Gray along off -> locking -> run
	typedef enum logic [1:0] {
		TX_OFF = 2'h0,
		TX_LOCKING = 2'h1,
		TX_RUN = 2'h3
	} psl_tx_state_e;

	// Parallel bit carried by a lane in a slot; both ends share it
	function automatic int bit_pos(input int lane, input int slot);
		return lane * SLOTS + slot;
	endfunction

endpackage

// ### hdl/psl_sync.sv
// Two-stage synchroniser for a bundle of asynchronous levels
module psl_sync
	import psl_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} psl_sync_s;

	psl_sync_s st_q;
	psl_sync_s st_d;

	// First stage feeds only the second stage
	always_comb begin
		st_d = st_q;
		st_d.meta = d;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '0;
		end else if (en) begin
			st_q <= st_d;
		end
	end

	assign q = st_q.stable;

endmodule

// ### dv/psl_far_tx.sv
// Far-end transmitter model feeding the receive lanes
module psl_far_tx
	import psl_pkg::*;
(
	input wire logic link_clk,
	input wire logic [27:0] word,
	input wire logic float_data,
	input wire logic float_clk,
	output logic [3:0] lane_t,
	output logic [3:0] lane_c,
	output logic clk_t,
	output logic clk_c
);
	timeunit 1ns;
	timeprecision 1ps;
	int slot = 0;
	initial {lane_t, lane_c, clk_t, clk_c} = 10'h000;
	// Launch on the falling edge so the receiver samples mid-bit
	always @(negedge link_clk) begin
		slot = (slot + 1) % SLOTS;
		for (int l = 0; l < LANES; l++) begin
			lane_t[l] = float_data | word[l * 7 + slot];
			lane_c[l] = float_data | !word[l * 7 + slot];
		end
		// Floating pair is shown as equal levels on both legs
		clk_t = float_clk | (slot < 4);
		clk_c = float_clk | (slot >= 4);
	end
endmodule

// ### dv/psl_link_chk.sv
// Port-level checks for the serial link block
module psl_link_chk
	import psl_pkg::*;
#(
	parameter int unsigned LOCK_CYCLES_P = 20
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic tx_power_down_n,
	input wire logic [3:0] serial_lane_out_true,
	input wire logic [3:0] serial_lane_out_comp,
	input wire logic forwarded_clock_out_true,
	input wire logic forwarded_clock_out_comp,
	input wire logic link_out_en,
	input wire logic forwarded_clock_in_true,
	input wire logic forwarded_clock_in_comp,
	input wire logic rx_power_down_n,
	input wire logic [27:0] parallel_word_out,
	input wire logic parallel_strobe_clock_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [31:0] on_q;
	logic [7:0] lost_q;
	logic lost;
	assign lost = forwarded_clock_in_true == forwarded_clock_in_comp;
	// Age counters; the lost-clock one saturates so it never wraps back
	always_ff @(posedge ref_clk) begin
		on_q <= (rst || !tx_power_down_n) ? 32'h0000_0000 : on_q + 32'h0000_0001;
		lost_q <= (rst || !lost) ? 8'h00 : lost_q + {7'h00, lost_q != 8'hff};
	end
	sequence s_rise_back;
		!parallel_strobe_clock_out ##1 parallel_strobe_clock_out;
	endsequence
	a_pairs_inverted: assert property (link_out_en |->
		{serial_lane_out_comp, forwarded_clock_out_comp} == ~{serial_lane_out_true, forwarded_clock_out_true})
		else $error("pair legs not inverted");
	a_off_quiet: assert property (!link_out_en |-> serial_lane_out_true == 4'h0 && !forwarded_clock_out_true)
		else $error("lanes active while disabled");
	a_pd_drops_en: assert property (!tx_power_down_n [*5] |-> !link_out_en)
		else $error("enable kept in power down");
	a_lock_wait: assert property ($rose(link_out_en) |-> on_q >= LOCK_CYCLES_P)
		else $error("enabled before lock wait");
	a_fwd_high_four: assert property ($fell(forwarded_clock_out_true) && link_out_en && $past(link_out_en, 5) |->
		$past(forwarded_clock_out_true, 4)) else $error("forwarded clock high phase short");
	a_rx_pd_zero: assert property (!rx_power_down_n [*5] |-> parallel_word_out == 28'h000_0000 && !parallel_strobe_clock_out)
		else $error("outputs not low in power down");
	a_strobe_pulse: assert property ($fell(parallel_strobe_clock_out) && rx_power_down_n &&
		$past(rx_power_down_n, 4) |-> ##1 s_rise_back) else $error("strobe low phase wrong");
	a_word_strobe_low: assert property ($changed(parallel_word_out) && rx_power_down_n &&
		$past(rx_power_down_n, 4) |-> !parallel_strobe_clock_out) else $error("word changed with strobe high");
	a_lost_clk_hold: assert property (lost_q >= 8'h64 && rx_power_down_n |->
		parallel_strobe_clock_out && $stable(parallel_word_out)) else $error("lost clock not held");
endmodule
bind psl_link psl_link_chk #(.LOCK_CYCLES_P(LOCK_CYCLES_P)) i_chk (.ref_clk, .rst, .tx_power_down_n,
	.serial_lane_out_true, .serial_lane_out_comp, .forwarded_clock_out_true, .forwarded_clock_out_comp,
	.link_out_en, .forwarded_clock_in_true, .forwarded_clock_in_comp, .rx_power_down_n, .parallel_word_out,
	.parallel_strobe_clock_out);

// ### dv/psl_link_tb.sv
// Self-checking bench for the serial link block
module psl_link_tb;
	import psl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, strobe_in = 1'b0, tx_pd_n = 1'b0, rx_pd_n = 1'b0;
	logic [27:0] word_in = 28'h000_0000, far_word = 28'h000_0000, got, word_out, w;
	logic [3:0] lane_t, lane_c, in_t, in_c;
	logic fwd_t, fwd_c, en, in_ck_t, in_ck_c, strobe_out, fwd_prev, st_prev;
	logic float_data = 1'b0, float_clk = 1'b0;
	logic [27:0] tx_exp[$], rx_exp[$];
	int errors = 0, checks = 0, sc = 7;
	// Link clock free running, no phase tie to ref_clk
	always #10 ref_clk = ~ref_clk;
	always #32 link_clk = ~link_clk;
	psl_link #(.LOCK_CYCLES_P(20)) i_dut (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .link_clk(link_clk),
		.parallel_strobe_clock_in(strobe_in), .parallel_word_in(word_in), .tx_power_down_n(tx_pd_n),
		.serial_lane_out_true(lane_t), .serial_lane_out_comp(lane_c), .forwarded_clock_out_true(fwd_t),
		.forwarded_clock_out_comp(fwd_c), .link_out_en(en), .serial_lane_in_true(in_t), .serial_lane_in_comp(in_c),
		.forwarded_clock_in_true(in_ck_t), .forwarded_clock_in_comp(in_ck_c), .rx_power_down_n(rx_pd_n),
		.parallel_word_out(word_out), .parallel_strobe_clock_out(strobe_out));
	psl_far_tx i_far (.link_clk(link_clk), .word(far_word), .float_data(float_data), .float_clk(float_clk),
		.lane_t(in_t), .lane_c(in_c), .clk_t(in_ck_t), .clk_c(in_ck_c));
	task automatic check(string what, logic [27:0] seen, logic [27:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		if (errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// A used-up wait is a mismatch and ends the run
	task automatic bound(logic ok);
		if (!ok) begin
			errors++;
			test_done();
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic drain();
		for (int k = 0; k < 60 && tx_exp.size() + rx_exp.size() > 0; k++) cyc(1);
		bound(tx_exp.size() + rx_exp.size() == 0);
	endtask
	// Frame collector on settled outputs; forwarded clock rise marks slot 0
	always @(negedge ref_clk) begin
		if (sc == 7 && tx_exp.size() > 0 && fwd_t === 1'b1 && fwd_prev === 1'b0) sc = 0;
		if (sc < 7) begin
			for (int l = 0; l < 4; l++) got[l * 7 + sc] = lane_t[l];
			check("lane_comp", {24'h00_0000, lane_c}, {24'h00_0000, ~lane_t});
			sc++;
			if (sc == 7) check("tx_word", got, tx_exp.pop_front());
		end
		fwd_prev = fwd_t;
		// Receive word taken at each strobe rise while a note waits
		if (rx_exp.size() > 0 && strobe_out === 1'b1 && st_prev === 1'b0) check("rx_word", word_out, rx_exp.pop_front());
		st_prev = strobe_out;
	end
	initial begin
		void'($urandom(32'hfcbc_c25b));
		cyc(12);
		rst = 1'b0;
		tx_pd_n = 1'b1;
		rx_pd_n = 1'b1;
		// Transmit: boundary then random words, again after a power-down
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 60 && en !== 1'b1; k++) cyc(1);
			bound(en === 1'b1);
			for (int i = 0; i < 4; i++) begin
				word_in = (i == 0) ? 28'h000_0000 : (i == 1) ? 28'hfff_ffff : 28'($urandom);
				cyc(3);
				strobe_in = 1'b1;
				cyc(4);
				strobe_in = 1'b0;
				cyc(2);
				tx_exp.push_back(word_in);
				drain();
			end
			tx_pd_n = 1'b0;
			cyc(6);
			check("link_out_en", {27'h000_0000, en}, 28'h000_0000);
			tx_pd_n = 1'b1;
		end
		// Receive: random words, one frame set with floating lanes
		for (int i = 0; i < 5; i++) begin
			far_word = 28'($urandom);
			float_data = (i == 3);
			cyc(90);
			rx_exp.push_back(float_data ? 28'hfff_ffff : far_word);
			drain();
		end
		w = far_word;
		float_clk = 1'b1;
		cyc(150);
		check("strobe_out", {27'h000_0000, strobe_out}, 28'h000_0001);
		check("held_word", word_out, w);
		float_clk = 1'b0;
		rx_pd_n = 1'b0;
		cyc(6);
		check("pd_word", word_out, 28'h000_0000);
		test_done();
	end
endmodule
